// *** include/fsclk_defs.vh ***
// constants of the fail-safe clock monitor
`ifndef FSCLK_DEFS_VH
`define FSCLK_DEFS_VH
// register byte offsets
`define FSCLK_CTRL_OFS     8'h00
`define FSCLK_OSCCTL_OFS   8'h04
`define FSCLK_STATUS_OFS   8'h08
`define FSCLK_MASK_OFS     8'h0c
`define FSCLK_STATE_OFS    8'h10
`define FSCLK_CFG_OFS      8'h14
// control register fields (write-only pulses)
`define FSCLK_CTRL_PM_BIT  0
`define FSCLK_CTRL_WAKE_BIT 1
// oscillator control register fields
`define FSCLK_SRC_LSB      0
`define FSCLK_SRC_MSB      1
`define FSCLK_RUN_BIT      3
`define FSCLK_OSCCTL_RST   2'h0
// status and mask fields
`define FSCLK_ST_FAIL_BIT  0
`define FSCLK_ST_RDY_BIT   1
`define FSCLK_STATUS_W     2
// configuration fields and reset value
`define FSCLK_CFG_MODE_LSB 0
`define FSCLK_CFG_MODE_MSB 2
`define FSCLK_CFG_MON_BIT  4
`define FSCLK_CFG_RST      5'h12
// clock sources
`define FSCLK_SRC_PRI      2'h0
`define FSCLK_SRC_SEC      2'h1
`define FSCLK_SRC_INT      2'h2
// primary oscillator modes
`define FSCLK_MODE_LP      3'h0
`define FSCLK_MODE_XT      3'h1
`define FSCLK_MODE_HS      3'h2
`define FSCLK_MODE_HIGH_SPEED_CRYSTAL_PLL_MODE   3'h3
`define FSCLK_MODE_EC      3'h4
`define FSCLK_MODE_RC      3'h5
`define FSCLK_MODE_INTERNAL_LOW_FREQ_OSC   3'h6
// timing
`define FSCLK_SAMPLE_DIV   64
`define FSCLK_OST_CYCLES   1024
`define FSCLK_CLK_MHZ      100
`define FSCLK_PLL_LOCK_US  2
`define FSCLK_PLL_CYCLES   (`FSCLK_PLL_LOCK_US * `FSCLK_CLK_MHZ)
`endif

// *** hdl/fsclk_sample_div.v ***
// sample clock divider: low-frequency oscillator divided down, as edge pulses
`include "fsclk_defs.vh"
module fsclk_sample_div #(
	parameter DIV = `FSCLK_SAMPLE_DIV
) (
	// system
	input  wire pclk,
	input  wire presetn,
	// low-frequency oscillator, sampled level
	input  wire lfosc_in,
	// sample clock edges
	output reg  samp_rise,
	output reg  samp_fall
);
	localparam integer HALF_I = DIV / 2;
	localparam [7:0]   HALF   = HALF_I[7:0];
	reg       lf_q;
	reg [7:0] cnt_reg;
	reg       samp_reg;
	wire      lf_rise = lfosc_in & ~lf_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lf_q      <= 1'b0;
			cnt_reg   <= 8'h00;
			samp_reg  <= 1'b0;
			samp_rise <= 1'b0;
			samp_fall <= 1'b0;
		end else begin
			lf_q      <= lfosc_in;
			samp_rise <= 1'b0;
			samp_fall <= 1'b0;
			if (lf_rise) begin
				// half period of HALF oscillator edges, so a full period of DIV
				if (cnt_reg == HALF - 8'h01) begin
					cnt_reg   <= 8'h00;
					samp_reg  <= ~samp_reg;
					samp_rise <= ~samp_reg;
					samp_fall <= samp_reg;
				end else begin
					cnt_reg <= cnt_reg + 8'h01;
				end
			end
		end
	end
endmodule // fsclk_sample_div

// *** hdl/fsclk_startup_timer.v ***
// start-up timer: oscillator edge count, then optional pll lock wait
`include "fsclk_defs.vh"
module fsclk_startup_timer #(
	parameter OST_CYCLES = `FSCLK_OST_CYCLES,
	parameter PLL_CYCLES = `FSCLK_PLL_CYCLES
) (
	// system
	input  wire pclk,
	input  wire presetn,
	// control
	input  wire run,
	input  wire use_pll,
	input  wire pri_clk_in,
	// status
	output reg  ready
);
	reg        clk_q;
	reg [15:0] ost_cnt;
	reg [15:0] pll_cnt;
	wire       ost_done = (ost_cnt == OST_CYCLES[15:0]);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_q   <= 1'b0;
			ost_cnt <= 16'h0000;
			pll_cnt <= 16'h0000;
			ready   <= 1'b0;
		end else begin
			clk_q <= pri_clk_in;
			if (!run) begin
				ost_cnt <= 16'h0000;
				pll_cnt <= 16'h0000;
				ready   <= 1'b0;
			end else if (!ost_done) begin
				if (pri_clk_in & ~clk_q)
					ost_cnt <= ost_cnt + 16'h0001;
			end else if (use_pll && pll_cnt != PLL_CYCLES[15:0]) begin
				pll_cnt <= pll_cnt + 16'h0001;
			end else begin
				ready <= 1'b1;
			end
		end
	end
endmodule // fsclk_startup_timer

// *** hdl/fsclk_top.v ***
// fail-safe clock monitor with clock source switching and apb registers
// Behaviour
// - fail-safe ends only on reset or power-managed entry
// - reset starts primary with its start-up delay
// - run from internal oscillator until primary ready
// - on ready switch to primary, set running flag
// - monitoring resumes after switching to primary
// - primary never ready: stay internal, register unchanged
// - power-managed entry selects register source, monitored
// - failure in power-managed mode: internal, no return
// - idle failure, interrupt off: interrupts resume on internal
// - external clock or rc modes monitor immediately
// - crystal modes run internal until timers expire
// - crystal never starting raises no failure flag
// - power-managed entry while waiting disables primary
// - sample clock is low-freq oscillator over 64
// - latch set by clock fall, cleared sample rise
// - sample fall with latch set means failure
// - failure: flag, switch internal, keep register, reset watchdog
`include "fsclk_defs.vh"
module fsclk_top #(
	parameter OST_CYCLES = `FSCLK_OST_CYCLES,
	parameter PLL_CYCLES = `FSCLK_PLL_CYCLES,
	parameter SAMPLE_DIV = `FSCLK_SAMPLE_DIV
) (
	// apb
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// oscillator inputs, sampled levels
	input  wire        pri_clk_in,
	input  wire        sec_clk_in,
	input  wire        lfosc_in,
	// core
	input  wire        idle_mode,
	input  wire        core_int_req,
	// clock tree and watchdog
	output reg  [1:0]  clk_sel_reg,
	output reg         pri_osc_en_reg,
	output reg         wdt_clear_reg,
	output reg         core_resume_reg,
	output reg         irq_reg
);
	localparam [3:0] ST_START = 4'h1;
	localparam [3:0] ST_PRI   = 4'h2;
	localparam [3:0] ST_FAIL  = 4'h4;
	localparam [3:0] ST_PM    = 4'h8;

	reg [3:0]  state_reg;
	reg [3:0]  state_next;
	reg [1:0]  src_reg;
	reg        run_flag_reg;
	reg [4:0]  cfg_reg;
	reg [1:0]  status_reg;
	reg [1:0]  mask_reg;
	reg        mon_latch_reg;
	reg        dev_clk_q;
	reg        mon_clk;
	reg        pend_sel_reg;
	reg [1:0]  pend_src_reg;
	reg        ready_q;
	wire       samp_rise;
	wire       samp_fall;
	wire       pri_ready;

	// apb decode
	wire       setup    = psel & ~penable;
	wire       wr_fire  = psel & penable & pready & pwrite;
	wire       hit      = (paddr == `FSCLK_CTRL_OFS)   | (paddr == `FSCLK_OSCCTL_OFS) |
	                      (paddr == `FSCLK_STATUS_OFS) | (paddr == `FSCLK_MASK_OFS) |
	                      (paddr == `FSCLK_STATE_OFS)  | (paddr == `FSCLK_CFG_OFS);
	wire       wr_ctrl  = wr_fire & (paddr == `FSCLK_CTRL_OFS);
	wire       pm_enter = wr_ctrl & pwdata[`FSCLK_CTRL_PM_BIT];
	wire       wake     = wr_ctrl & pwdata[`FSCLK_CTRL_WAKE_BIT];
	wire [2:0] mode     = cfg_reg[`FSCLK_CFG_MODE_MSB:`FSCLK_CFG_MODE_LSB];
	wire       mon_en   = cfg_reg[`FSCLK_CFG_MON_BIT];
	wire       xtal     = (mode == `FSCLK_MODE_LP) | (mode == `FSCLK_MODE_XT) |
	                      (mode == `FSCLK_MODE_HS) | (mode == `FSCLK_MODE_HIGH_SPEED_CRYSTAL_PLL_MODE);

	fsclk_sample_div #(
		.DIV (SAMPLE_DIV)
	) u_div (
		.pclk      (pclk),
		.presetn   (presetn),
		.lfosc_in  (lfosc_in),
		.samp_rise (samp_rise),
		.samp_fall (samp_fall)
	);

	fsclk_startup_timer #(
		.OST_CYCLES (OST_CYCLES),
		.PLL_CYCLES (PLL_CYCLES)
	) u_ost (
		.pclk       (pclk),
		.presetn    (presetn),
		.run        (pri_osc_en_reg & (state_reg == ST_START)),
		.use_pll    (mode == `FSCLK_MODE_HIGH_SPEED_CRYSTAL_PLL_MODE),
		.pri_clk_in (pri_clk_in),
		.ready      (pri_ready)
	);

	// monitored clock follows the active source
	always @* begin
		case (clk_sel_reg)
			`FSCLK_SRC_PRI: mon_clk = pri_clk_in;
			`FSCLK_SRC_SEC: mon_clk = sec_clk_in;
			default:        mon_clk = 1'b0;
		endcase
	end

	// only an external source in a monitored state can fail
	wire monitoring = mon_en & (clk_sel_reg != `FSCLK_SRC_INT) &
	                  ((state_reg == ST_PRI) | (state_reg == ST_PM));
	wire fail_det   = monitoring & samp_fall & mon_latch_reg;
	// crystal modes wait out the timer; other modes switch at once
	wire pri_go     = ~xtal | pri_ready;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_START: begin
				if (pm_enter)
					state_next = ST_PM;
				else if (pri_go)
					state_next = ST_PRI;
				// no timeout here: a dead crystal simply leaves us waiting
			end
			ST_PRI: begin
				if (pm_enter)
					state_next = ST_PM;
				else if (fail_det)
					state_next = ST_FAIL;
				else if (wake & xtal)
					state_next = ST_START;
			end
			ST_FAIL: begin
				// only power-managed entry leaves; reset is the other way out
				if (pm_enter)
					state_next = ST_PM;
			end
			ST_PM: begin
				if (fail_det)
					state_next = ST_FAIL;
				else if (wake)
					state_next = xtal ? ST_START : ST_PRI;
				else if (pm_enter)
					state_next = ST_PM;
			end
			default: state_next = ST_START;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg       <= ST_START;
			src_reg         <= `FSCLK_OSCCTL_RST;
			run_flag_reg    <= 1'b0;
			cfg_reg         <= `FSCLK_CFG_RST;
			status_reg      <= {`FSCLK_STATUS_W{1'b0}};
			mask_reg        <= {`FSCLK_STATUS_W{1'b0}};
			mon_latch_reg   <= 1'b0;
			dev_clk_q       <= 1'b0;
			pend_sel_reg    <= 1'b1;
			pend_src_reg    <= `FSCLK_SRC_INT;
			ready_q         <= 1'b0;
			clk_sel_reg     <= `FSCLK_SRC_INT;
			pri_osc_en_reg  <= 1'b1;
			wdt_clear_reg   <= 1'b0;
			core_resume_reg <= 1'b0;
			irq_reg         <= 1'b0;
			prdata          <= 32'h0000_0000;
			pready          <= 1'b0;
			pslverr         <= 1'b0;
		end else begin
			state_reg     <= state_next;
			dev_clk_q     <= mon_clk;
			ready_q       <= pri_ready;
			wdt_clear_reg <= fail_det;
			// a falling device clock beats a same-cycle sample rise
			if (dev_clk_q & ~mon_clk)
				mon_latch_reg <= 1'b1;
			else if (samp_rise)
				mon_latch_reg <= 1'b0;

			// pick the wanted source; it reaches the mux on a sample edge
			if (state_next != state_reg || pm_enter) begin
				pend_sel_reg <= 1'b1;
				case (state_next)
					ST_PRI:  pend_src_reg <= `FSCLK_SRC_PRI;
					// code 3 also means internal, so the mux never sees it
					ST_PM:   pend_src_reg <= (src_reg == 2'h3) ? `FSCLK_SRC_INT : src_reg;
					default: pend_src_reg <= `FSCLK_SRC_INT;
				endcase
			end else if (pend_sel_reg & (samp_rise | samp_fall)) begin
				pend_sel_reg <= 1'b0;
				clk_sel_reg  <= pend_src_reg;
			end

			// primary enable: off when leaving start-up for a managed mode
			if (state_reg == ST_START && state_next == ST_PM)
				pri_osc_en_reg <= 1'b0;
			else if (state_next == ST_START || state_next == ST_PRI)
				pri_osc_en_reg <= 1'b1;
			else if (state_next == ST_PM && pm_enter)
				pri_osc_en_reg <= (src_reg == `FSCLK_SRC_PRI);

			// running flag; untouched by a failure
			if (state_reg == ST_START && state_next == ST_PRI)
				run_flag_reg <= 1'b1;
			else if (state_next == ST_START)
				run_flag_reg <= 1'b0;
			else if (pm_enter)
				run_flag_reg <= (src_reg == `FSCLK_SRC_PRI);

			// resume the core from idle on the internal clock
			core_resume_reg <= (state_reg == ST_FAIL) & idle_mode &
			                   (mask_reg[`FSCLK_ST_FAIL_BIT] ? status_reg[`FSCLK_ST_FAIL_BIT]
			                                                 : core_int_req);
			if (fail_det & idle_mode & mask_reg[`FSCLK_ST_FAIL_BIT])
				core_resume_reg <= 1'b1;

			// sticky status, write one to clear, a new event wins
			if (wr_fire && paddr == `FSCLK_STATUS_OFS)
				status_reg <= (status_reg & ~pwdata[`FSCLK_STATUS_W-1:0]) |
				              {pri_ready & ~ready_q, fail_det};
			else
				status_reg <= status_reg | {pri_ready & ~ready_q, fail_det};
			irq_reg <= |(status_reg & mask_reg);

			// register writes
			if (wr_fire) begin
				case (paddr)
					`FSCLK_OSCCTL_OFS: src_reg  <= pwdata[`FSCLK_SRC_MSB:`FSCLK_SRC_LSB];
					`FSCLK_MASK_OFS:   mask_reg <= pwdata[`FSCLK_STATUS_W-1:0];
					`FSCLK_CFG_OFS:    cfg_reg  <= pwdata[4:0];
					default:           ;
				endcase
			end

			// zero-wait apb: answer in the access cycle
			pready  <= setup;
			pslverr <= setup & ~hit;
			if (setup) begin
				case (paddr)
					`FSCLK_OSCCTL_OFS: prdata <= {28'h0, run_flag_reg, 1'b0, src_reg};
					`FSCLK_STATUS_OFS: prdata <= {30'h0, status_reg};
					`FSCLK_MASK_OFS:   prdata <= {30'h0, mask_reg};
					`FSCLK_STATE_OFS:  prdata <= {26'h0, clk_sel_reg, state_reg};
					`FSCLK_CFG_OFS:    prdata <= {27'h0, cfg_reg};
					default:           prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // fsclk_top

// *** test/fsclk_osc_model.sv ***
// oscillator sources feeding the monitor
module fsclk_osc_model (
	// system and test controls
	input  wire  pclk,
	input  wire  pri_osc_en,
	input  wire  pri_on,
	input  wire  sec_on,
	// oscillator levels
	output logic pri_clk_in,
	output logic sec_clk_in,
	output logic lfosc_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt = 3'h0;
	always @(posedge pclk) cnt <= cnt + 3'h1;
	// a dead or disabled crystal holds low, so it gives no edges
	assign pri_clk_in = pri_osc_en & pri_on & cnt[1];
	assign sec_clk_in = sec_on & cnt[1];
	// runs free: it is the backup source
	assign lfosc_in = cnt[2];
endmodule // fsclk_osc_model

// *** test/fsclk_top_sva.sv ***
// port assertions of the clock monitor
module fsclk_top_sva (
	// apb
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire [7:0]  paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// clock tree
	input wire [1:0]  clk_sel_reg,
	input wire        pri_osc_en_reg,
	input wire        wdt_clear_reg,
	input wire        core_resume_reg
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	chk_pready_once: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_bad_addr: assert property (psel && !penable && paddr > 8'h14 |=> pslverr && prdata == 0)
		else $error("unmapped access accepted");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_reset_sel: assert property (!$past(presetn) |-> clk_sel_reg == 2'h2 && pri_osc_en_reg)
		else $error("bad clock after reset");
	chk_wdt_pulse: assert property (wdt_clear_reg |=> !wdt_clear_reg)
		else $error("watchdog clear too long");
	chk_fail_switch: assert property (wdt_clear_reg |-> ##[0:300] clk_sel_reg == 2'h2)
		else $error("no switch after failure");
	chk_sel_legal: assert property (clk_sel_reg != 2'h3)
		else $error("illegal clock select");
	cover property (wdt_clear_reg);
	cover property (clk_sel_reg == 2'h1);
	cover property (pslverr);
	cover property (core_resume_reg);
endmodule // fsclk_top_sva
bind fsclk_top fsclk_top_sva u_sva (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
	.pready, .pslverr, .clk_sel_reg, .pri_osc_en_reg, .wdt_clear_reg, .core_resume_reg);

// *** test/fsclk_tb_top.sv ***
// testbench of the fail-safe clock monitor
module fsclk_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        pri_clk_in, sec_clk_in, lfosc_in, idle_mode, core_int_req;
	logic        pri_osc_en_reg, wdt_clear_reg, core_resume_reg, irq_reg;
	logic        pri_on, sec_on;
	logic [1:0]  clk_sel_reg;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	integer      err_count, checks;
	// short start-up counts keep the run brief
	fsclk_top #(.OST_CYCLES(8), .PLL_CYCLES(4), .SAMPLE_DIV(8)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pri_clk_in(pri_clk_in), .sec_clk_in(sec_clk_in), .lfosc_in(lfosc_in),
		.idle_mode(idle_mode), .core_int_req(core_int_req), .clk_sel_reg(clk_sel_reg),
		.pri_osc_en_reg(pri_osc_en_reg), .wdt_clear_reg(wdt_clear_reg),
		.core_resume_reg(core_resume_reg), .irq_reg(irq_reg));
	fsclk_osc_model osc (.pclk(pclk), .pri_osc_en(pri_osc_en_reg), .pri_on(pri_on),
		.sec_on(sec_on), .pri_clk_in(pri_clk_in), .sec_clk_in(sec_clk_in),
		.lfosc_in(lfosc_in));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks = checks + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rv, e);
	endtask
	task poll(input logic [7:0] a, input logic [31:0] e);
		integer i;
		rv = 32'hx;
		for (i = 0; i < 60 && rv !== e; i++) apb(1'b0, a, 32'h0);
		chk(rv, e);
	endtask
	task wait_sel(input logic [1:0] v);
		integer i;
		for (i = 0; i < 300 && clk_sel_reg !== v; i++) @(posedge pclk);
		chk(clk_sel_reg, v);
	endtask
	task wait_wdt;
		integer i;
		for (i = 0; i < 300 && wdt_clear_reg !== 1'b1; i++) @(posedge pclk);
		chk(wdt_clear_reg, 1'b1);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, idle_mode, core_int_req, presetn} = 6'h0;
		{paddr, pwdata} = 40'h0;
		{pri_on, sec_on} = 2'h3;
		err_count = 0;
		checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h14, 32'h12);
		rd(8'h04, 32'h0);
		rd(8'h10, 32'h21);
		rd(8'h18, 32'h0);
		$display("test reset done");
		poll(8'h10, 32'h02);
		rd(8'h04, 32'h8);
		rd(8'h08, 32'h2);
		chk(irq_reg, 1'b0);
		apb(1'b1, 8'h0c, 32'h2);
		repeat (2) @(posedge pclk);
		chk(irq_reg, 1'b1);
		apb(1'b1, 8'h08, 32'h2);
		repeat (2) @(posedge pclk);
		chk(irq_reg, 1'b0);
		$display("test startup done");
		// a running source sets the latch again before every sample fall
		wait_wdt;
		wait_sel(2'h2);
		rd(8'h08, 32'h1);
		rd(8'h04, 32'h8);
		repeat (100) @(posedge pclk);
		rd(8'h10, 32'h24);
		chk(clk_sel_reg, 2'h2);
		{idle_mode, core_int_req} <= 2'h3;
		repeat (3) @(posedge pclk);
		chk(core_resume_reg, 1'b1);
		{idle_mode, core_int_req} <= 2'h0;
		apb(1'b1, 8'h08, 32'h1);
		$display("test failure done");
		// a stopped secondary leaves the latch clear, so nothing is flagged
		sec_on <= 1'b0;
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, 8'h00, 32'h1);
		wait_sel(2'h1);
		rd(8'h10, 32'h18);
		repeat (64) @(posedge pclk);
		rd(8'h08, 32'h0);
		sec_on <= 1'b1;
		wait_wdt;
		wait_sel(2'h2);
		$display("test power managed done");
		apb(1'b1, 8'h14, 32'h14);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h00, 32'h2);
		poll(8'h10, 32'h02);
		wait_wdt;
		$display("test wake done");
		// second reset with a crystal that never starts
		pri_on <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (300) @(posedge pclk);
		rd(8'h10, 32'h21);
		rd(8'h08, 32'h0);
		rd(8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		repeat (2) @(posedge pclk);
		chk(pri_osc_en_reg, 1'b0);
		// pll crystal woken with the monitor off, so only start-up is seen
		apb(1'b1, 8'h14, 32'h03);
		pri_on <= 1'b1;
		apb(1'b1, 8'h00, 32'h2);
		poll(8'h10, 32'h02);
		$display("test dead crystal done");
		give_verdict;
	end
	initial begin
		#100000;
		err_count = err_count + 1;
		give_verdict;
	end
endmodule // fsclk_tb_top
